/* design/sfq_pkg.sv */
package sfq_pkg;

  // ------------------------------------------------------------------
  // Capacity limits and register map
  // ------------------------------------------------------------------
  localparam int          SFQ_DEPTH_MIN  = 16;
  localparam int          SFQ_DEPTH_MAX  = 4194304;
  localparam int          SFQ_APB_AW     = 12;
  localparam logic [11:0] SFQ_OFS_CTRL   = 12'h000;
  localparam logic [11:0] SFQ_OFS_STAT   = 12'h004;
  localparam logic [11:0] SFQ_OFS_COUNT  = 12'h008;
  localparam logic [11:0] SFQ_OFS_DEPTH  = 12'h00C;

  // ------------------------------------------------------------------
  // Field positions and values after reset
  // ------------------------------------------------------------------
  localparam int          SFQ_CTRL_FLUSH = 0;
  localparam int          SFQ_CTRL_HOLD  = 1;
  localparam int          SFQ_STAT_EMPTY = 0;
  localparam int          SFQ_STAT_FULL  = 1;
  localparam int          SFQ_STAT_HOLD  = 2;
  localparam logic        SFQ_HOLD_RST   = 1'b0;
  localparam logic [31:0] SFQ_RDATA_RST  = 32'h0000_0000;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [SFQ_APB_AW-1:0] paddr;
    logic [31:0]           pwdata;
  } sfq_apb_req_type;

  typedef enum logic [1:0] {
    SFQ_APB_IDLE = 2'b01,
    SFQ_APB_RESP = 2'b10
  } sfq_apb_state_type;

endpackage

/* design/sfq_store.sv */
`timescale 1ns/1ps
`default_nettype none

module sfq_store #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic             i_mclk,
  input  wire logic             i_we,
  input  wire logic [AW-1:0]    i_waddr,
  input  wire logic [WIDTH-1:0] i_wdata,
  input  wire logic [AW-1:0]    i_raddr,
  output logic      [WIDTH-1:0] o_rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // ------------------------------------------------------------------
  // Registered read, write-first
  // ------------------------------------------------------------------
  // The bypass lets a word written into an empty queue show at the
  // output one edge later, without an extra prefetch stage.
  always_ff @(posedge i_mclk) begin
    if (i_we && (i_waddr == i_raddr)) begin
      o_rdata <= i_wdata;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end

endmodule // sfq_store

`default_nettype wire

/* design/sfq_queue.sv */
`timescale 1ns/1ps
`default_nettype none

// Function
// - Transfer only when valid and ready high
// - Write ready only when a word fits
// - Requested depth parameter, sixteen to four mebiwords
// - Built depth reported as derived parameter
// - Payload width is whole bytes
// - Strobe: one bit per byte, LSB first
// - Keep: one bit per byte, same order
// - Last flag travels with its word
// - Dest, id, user travel with word
// - Optional global reset empties queue
// - Occupancy count never below stored words
// - Write shows in count next edge
// - Count is log2 depth plus one wide
// - One clock; block or distributed storage
// - Read side shows oldest word
module sfq_queue
  import sfq_pkg::*;
#(
  parameter int DEPTH      = 16,
  parameter int DATA_BYTES = 4,
  parameter int DEST_W     = 4,
  parameter int ID_W       = 4,
  parameter int USER_W     = 8,
  parameter bit USE_STRB   = 1'b1,
  parameter bit USE_KEEP   = 1'b1,
  parameter bit USE_LAST   = 1'b1,
  parameter bit USE_DEST   = 1'b1,
  parameter bit USE_ID     = 1'b1,
  parameter bit USE_USER   = 1'b1,
  parameter bit USE_ARST   = 1'b1,
  parameter bit USE_COUNT  = 1'b1,
  parameter bit MEM_BLOCK  = 1'b1,
  // Derived values, not meant to be overridden
  parameter int ACT_DEPTH  = MEM_BLOCK ? (1 << $clog2(DEPTH)) : DEPTH,
  parameter int CW         = $clog2(ACT_DEPTH) + 1
) (
  input  wire logic                    i_mclk,
  input  wire logic                    i_srst,
  input  wire logic                    i_arestn,
  input  wire sfq_apb_req_type         i_apb,
  output logic     [31:0]              o_prdata,
  output logic                         o_pready,
  output logic                         o_pslverr,
  input  wire logic                    i_s_tvalid,
  output logic                         o_s_tready,
  input  wire logic [DATA_BYTES*8-1:0] i_s_tdata,
  input  wire logic [DATA_BYTES-1:0]   i_s_tstrb,
  input  wire logic [DATA_BYTES-1:0]   i_s_tkeep,
  input  wire logic                    i_s_tlast,
  input  wire logic [DEST_W-1:0]       i_s_tdest,
  input  wire logic [ID_W-1:0]         i_s_tid,
  input  wire logic [USER_W-1:0]       i_s_tuser,
  output logic                         o_m_tvalid,
  input  wire logic                    i_m_tready,
  output logic     [DATA_BYTES*8-1:0]  o_m_tdata,
  output logic     [DATA_BYTES-1:0]    o_m_tstrb,
  output logic     [DATA_BYTES-1:0]    o_m_tkeep,
  output logic                         o_m_tlast,
  output logic     [DEST_W-1:0]        o_m_tdest,
  output logic     [ID_W-1:0]          o_m_tid,
  output logic     [USER_W-1:0]        o_m_tuser,
  output logic     [CW-1:0]            o_data_count
);

  // ------------------------------------------------------------------
  // Derived sizes
  // ------------------------------------------------------------------
  localparam int             DW   = DATA_BYTES * 8;
  localparam int             AW   = $clog2(ACT_DEPTH);
  localparam int             WW   = DW + 2 * DATA_BYTES + 1 + DEST_W + ID_W + USER_W;
  localparam logic [AW-1:0]  LAST = AW'(ACT_DEPTH - 1);
  localparam logic [CW-1:0]  FULL = CW'(ACT_DEPTH);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic              push;
  logic              pop;
  logic              clear;
  logic              flush_reg;
  logic              hold_reg;
  logic              hold_next;
  logic              offer_reg;
  logic              valid_reg;
  logic              ready_reg;
  logic [CW-1:0]     count_reg;
  logic [CW-1:0]     count_next;
  logic [AW-1:0]     wptr_reg;
  logic [AW-1:0]     rptr_reg;
  logic [AW-1:0]     rptr_next;
  logic [WW-1:0]     wr_word;
  logic [WW-1:0]     rd_word;
  logic [31:0]       rd_val;
  logic              rd_err;
  logic              apb_done;
  sfq_apb_state_type apb_state_reg;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == LAST) ? '0 : p + 1'b1;
  endfunction

  // ------------------------------------------------------------------
  // Handshakes and clear
  // ------------------------------------------------------------------
  assign push  = i_s_tvalid & ready_reg;
  assign pop   = offer_reg & i_m_tready;
  assign clear = i_srst | (USE_ARST & ~i_arestn) | flush_reg;

  always_comb begin
    count_next = count_reg;
    unique case ({push, pop})
      2'b10:   count_next = count_reg + 1'b1;
      2'b01:   count_next = count_reg - 1'b1;
      default: count_next = count_reg;
    endcase
  end

  assign rptr_next = pop ? ptr_inc(rptr_reg) : rptr_reg;

  // ------------------------------------------------------------------
  // Occupancy and pointers
  // ------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (clear) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (clear) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= ptr_inc(wptr_reg);
      end
      rptr_reg <= rptr_next;
    end
  end

  // Flags are registered from count_next so the ports need no logic.
  // Hold is folded into the offer a cycle early, so read valid is a flop.
  always_ff @(posedge i_mclk) begin
    if (clear) begin
      valid_reg <= 1'b0;
      ready_reg <= 1'b0;
      offer_reg <= 1'b0;
    end else begin
      valid_reg <= (count_next != '0);
      ready_reg <= (count_next != FULL);
      offer_reg <= (count_next != '0) & ~hold_next;
    end
  end

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  // Disabled sidebands store zero so synthesis can trim those bits.
  assign wr_word = {USE_LAST ? i_s_tlast : 1'b0,
                    USE_USER ? i_s_tuser : {USER_W{1'b0}},
                    USE_ID   ? i_s_tid   : {ID_W{1'b0}},
                    USE_DEST ? i_s_tdest : {DEST_W{1'b0}},
                    USE_KEEP ? i_s_tkeep : {DATA_BYTES{1'b0}},
                    USE_STRB ? i_s_tstrb : {DATA_BYTES{1'b0}},
                    i_s_tdata};

  sfq_store #(
    .WIDTH (WW),
    .DEPTH (ACT_DEPTH),
    .AW    (AW)
  ) u_store (
    .i_mclk  (i_mclk),
    .i_we    (push),
    .i_waddr (wptr_reg),
    .i_wdata (wr_word),
    .i_raddr (rptr_next),
    .o_rdata (rd_word)
  );

  assign {o_m_tlast, o_m_tuser, o_m_tid, o_m_tdest,
          o_m_tkeep, o_m_tstrb, o_m_tdata} = rd_word;

  assign o_s_tready   = ready_reg;
  assign o_m_tvalid   = offer_reg;
  assign o_data_count = USE_COUNT ? count_reg : '0;

  // ------------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------------
  always_comb begin
    rd_val = SFQ_RDATA_RST;
    rd_err = 1'b0;
    unique case (i_apb.paddr)
      SFQ_OFS_CTRL:  rd_val[SFQ_CTRL_HOLD] = hold_reg;
      SFQ_OFS_STAT: begin
        rd_val[SFQ_STAT_EMPTY] = ~valid_reg;
        rd_val[SFQ_STAT_FULL]  = ~ready_reg;
        rd_val[SFQ_STAT_HOLD]  = hold_reg;
      end
      SFQ_OFS_COUNT: rd_val[CW-1:0] = count_reg;
      SFQ_OFS_DEPTH: rd_val = 32'(ACT_DEPTH);
      default:       rd_err = 1'b1;
    endcase
  end

  // One wait state: pready rises the cycle after the access phase opens
  assign apb_done = (apb_state_reg == SFQ_APB_RESP) & i_apb.psel & i_apb.penable;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      apb_state_reg <= SFQ_APB_IDLE;
      o_pready      <= 1'b0;
      o_prdata      <= SFQ_RDATA_RST;
      o_pslverr     <= 1'b0;
    end else begin
      unique case (apb_state_reg)
        SFQ_APB_IDLE: begin
          if (i_apb.psel && i_apb.penable) begin
            apb_state_reg <= SFQ_APB_RESP;
            o_pready      <= 1'b1;
            o_prdata      <= i_apb.pwrite ? SFQ_RDATA_RST : rd_val;
            o_pslverr     <= rd_err;
          end
        end
        SFQ_APB_RESP: begin
          apb_state_reg <= SFQ_APB_IDLE;
          o_pready      <= 1'b0;
          o_prdata      <= SFQ_RDATA_RST;
          o_pslverr     <= 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    hold_next = hold_reg;
    if (apb_done && i_apb.pwrite && (i_apb.paddr == SFQ_OFS_CTRL)) begin
      hold_next = i_apb.pwdata[SFQ_CTRL_HOLD];
    end
  end

  // Flush is a one-cycle pulse; hold stalls only the read side
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      flush_reg <= 1'b0;
      hold_reg  <= SFQ_HOLD_RST;
    end else begin
      flush_reg <= 1'b0;
      hold_reg  <= hold_next;
      if (apb_done && i_apb.pwrite && (i_apb.paddr == SFQ_OFS_CTRL)) begin
        flush_reg <= i_apb.pwdata[SFQ_CTRL_FLUSH];
      end
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  logic [DW-1:0] head_seen_reg;
  logic          head_held_reg;

  always_ff @(posedge i_mclk) begin
    head_seen_reg <= o_m_tdata;
    head_held_reg <= o_m_tvalid & ~i_m_tready & ~clear;
  end

  sequence s_push_only;
    push && !pop && !clear;
  endsequence

  sequence s_pop_only;
    pop && !push && !clear;
  endsequence

  a_depth_range: assert property (@(posedge i_mclk)
    (DEPTH >= SFQ_DEPTH_MIN) && (DEPTH <= SFQ_DEPTH_MAX))
    else $error("requested depth out of range");

  a_actual_cover: assert property (@(posedge i_mclk)
    (ACT_DEPTH >= DEPTH) && (CW == $clog2(ACT_DEPTH) + 1))
    else $error("built depth below requested depth");

  a_no_push_full: assert property (@(posedge i_mclk) disable iff (i_srst)
    (count_reg == FULL) |-> !o_s_tready)
    else $error("write ready while queue full");

  a_valid_stored: assert property (@(posedge i_mclk) disable iff (clear)
    (count_reg != '0) |-> valid_reg)
    else $error("stored word not offered");

  a_count_up: assert property (@(posedge i_mclk) disable iff (i_srst)
    s_push_only |=> (count_reg == $past(count_reg) + 1'b1))
    else $error("write not counted at next edge");

  a_count_down: assert property (@(posedge i_mclk) disable iff (i_srst)
    s_pop_only |=> (count_reg == $past(count_reg) - 1'b1))
    else $error("read not removed from count");

  a_clear_empty: assert property (@(posedge i_mclk)
    clear |=> (count_reg == '0) && !o_m_tvalid && !o_s_tready)
    else $error("reset did not empty queue");

  a_head_stable: assert property (@(posedge i_mclk) disable iff (clear)
    head_held_reg |-> (o_m_tdata == head_seen_reg))
    else $error("head word changed before taken");

  a_fill_order: assert property (@(posedge i_mclk) disable iff (clear)
    (s_push_only ##0 (count_reg == '0)) |=> o_m_tvalid || hold_reg
      ##0 (o_m_tdata == $past(i_s_tdata)))
    else $error("first word not presented in order");

endmodule // sfq_queue

`default_nettype wire

/* tb/sfq_sink.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Downstream stream slave
// ------------------------------------------------------------------
module sfq_sink (
  input  wire logic i_mclk,
  input  wire logic i_srst,
  input  wire logic i_busy,
  input  wire logic i_valid,
  output logic      o_ready,
  output logic      o_take
);
  // Registered ready, so a stall lands one cycle after it is asked for
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_ready <= 1'b0;
    end else begin
      o_ready <= ~i_busy;
    end
  end

  // Head word is taken only where valid and ready meet
  assign o_take = i_valid & o_ready;
endmodule // sfq_sink

`default_nettype wire

/* tb/tb_stream_fifo_queue.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_stream_fifo_queue;
  import sfq_pkg::*;
  localparam int DEPTH = 20;
  localparam int ACT   = 1 << $clog2(DEPTH);
  localparam int CW    = $clog2(ACT) + 1;
  typedef struct packed {
    logic [31:0] data;
    logic [3:0]  strb;
    logic [3:0]  keep;
    logic        last;
    logic [3:0]  dest;
    logic [3:0]  id;
    logic [7:0]  user;
  } sfq_word_type;

  logic            i_mclk, i_srst, i_arestn, s_valid, s_ready, m_valid, m_ready, take;
  logic            busy, stall, rnd_stall, flushing, hold_on, rst_d, pready, pslverr;
  logic [31:0]     prdata;
  logic [CW-1:0]   count;
  sfq_apb_req_type apb;
  sfq_word_type    s_word;
  wire sfq_word_type m_word;
  sfq_word_type    expq[$];
  int              errors, comparisons, occ;
  integer          seed = 32'h9E88980A;

  sfq_queue #(.DEPTH(DEPTH)) uut (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_arestn(i_arestn), .i_apb(apb),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_s_tvalid(s_valid), .o_s_tready(s_ready), .i_s_tdata(s_word.data),
    .i_s_tstrb(s_word.strb), .i_s_tkeep(s_word.keep), .i_s_tlast(s_word.last),
    .i_s_tdest(s_word.dest), .i_s_tid(s_word.id), .i_s_tuser(s_word.user),
    .o_m_tvalid(m_valid), .i_m_tready(m_ready), .o_m_tdata(m_word.data),
    .o_m_tstrb(m_word.strb), .o_m_tkeep(m_word.keep), .o_m_tlast(m_word.last),
    .o_m_tdest(m_word.dest), .o_m_tid(m_word.id), .o_m_tuser(m_word.user),
    .o_data_count(count)
  );

  sfq_sink sink (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_busy(busy), .i_valid(m_valid),
    .o_ready(m_ready), .o_take(take)
  );

  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end

  // ------------------------------------------------------------------
  // Compare and bus tasks
  // ------------------------------------------------------------------
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_word(input sfq_word_type got, input sfq_word_type exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb_rw(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge i_mclk);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge i_mclk);
    apb.penable <= 1'b1;
    do begin
      @(posedge i_mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    rd = prdata;
    err = pslverr;
    apb <= '0;
  endtask

  // The word stays on the lines until the edge that takes it
  task automatic push(input sfq_word_type w);
    int n;
    n = 0;
    s_valid <= 1'b1;
    s_word <= w;
    do begin
      @(posedge i_mclk);
      n++;
    end while (s_ready !== 1'b1 && n < 400);
    if (n >= 400) errors++;
    expq.push_back(w);
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (expq.size() != 0 && n < 500) begin
      @(posedge i_mclk);
      n++;
    end
    if (expq.size() != 0) begin
      errors++;
      $display("mismatch at %0t: words left undelivered", $time);
    end
  endtask

  function automatic sfq_word_type rnd_word();
    logic [63:0] r;
    r = {$random(seed), $random(seed)};
    return r[$bits(sfq_word_type)-1:0];
  endfunction

  task automatic give_verdict();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Output monitor and occupancy model
  // ------------------------------------------------------------------
  always @(posedge i_mclk) begin
    busy <= rnd_stall ? 1'($random(seed)) : stall;
    rst_d <= i_srst || !i_arestn || flushing;
    if (i_srst || !i_arestn || flushing) begin
      occ <= 0;
    end else begin
      if (!rst_d) begin
        cmp_val(32'(count), 32'(occ), "count");
        cmp_val(32'(s_ready), 32'(occ < ACT), "write ready");
        if (!hold_on) cmp_val(32'(m_valid), 32'(occ > 0), "read valid");
      end
      if (take === 1'b1) begin
        if (expq.size() == 0) cmp_val(32'(take), 32'h0, "extra word");
        else cmp_word(m_word, expq.pop_front());
      end
      occ <= occ + int'(s_valid === 1'b1 && s_ready === 1'b1) - int'(take === 1'b1);
    end
  end

  initial begin
    repeat (20000) @(posedge i_mclk);
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    give_verdict();
  end

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial begin
    logic [31:0] rd;
    logic        err;
    i_srst = 1'b1;
    i_arestn = 1'b1;
    apb = '0;
    s_valid = 1'b0;
    s_word = '0;
    stall = 1'b1;
    rnd_stall = 1'b0;
    flushing = 1'b0;
    hold_on = 1'b0;
    repeat (12) @(posedge i_mclk);
    i_srst <= 1'b0;
    repeat (2) @(posedge i_mclk);
    cmp_val(32'($bits(uut.o_data_count)), 32'(CW), "count width");
    apb_rw(1'b0, SFQ_OFS_DEPTH, 32'h0, rd, err);
    cmp_val(rd, 32'(ACT), "built depth");
    apb_rw(1'b0, SFQ_OFS_STAT, 32'h0, rd, err);
    cmp_val(rd, 32'h1, "status empty");
    apb_rw(1'b1, SFQ_OFS_COUNT, 32'hFFFF, rd, err);
    cmp_val(32'(err), 32'h0, "ignored write error");
    apb_rw(1'b0, 12'h010, 32'h0, rd, err);
    cmp_val({rd[30:0], err}, 32'h1, "unmapped read");
    // Fill with ACT words, up to full, while the sink stalls
    for (int i = 0; i < ACT; i++) push(rnd_word());
    s_valid <= 1'b0;
    apb_rw(1'b0, SFQ_OFS_STAT, 32'h0, rd, err);
    cmp_val(rd, 32'h2, "status full");
    apb_rw(1'b0, SFQ_OFS_COUNT, 32'h0, rd, err);
    cmp_val(rd, 32'(ACT), "count register full");
    // Refused word held until room appears, then a long random run
    rnd_stall <= 1'b1;
    for (int i = 0; i < 40; i++) push(rnd_word());
    s_valid <= 1'b0;
    drain();
    // Read side held off by the control hold bit
    rnd_stall <= 1'b0;
    stall <= 1'b0;
    hold_on <= 1'b1;
    apb_rw(1'b1, SFQ_OFS_CTRL, 32'h2, rd, err);
    for (int i = 0; i < 3; i++) push(rnd_word());
    s_valid <= 1'b0;
    repeat (4) @(posedge i_mclk);
    cmp_val(32'(m_valid), 32'h0, "valid under hold");
    apb_rw(1'b0, SFQ_OFS_STAT, 32'h0, rd, err);
    cmp_val(rd, 32'h4, "status hold");
    apb_rw(1'b0, SFQ_OFS_CTRL, 32'h0, rd, err);
    cmp_val(rd, 32'h2, "hold readback");
    apb_rw(1'b0, SFQ_OFS_COUNT, 32'h0, rd, err);
    cmp_val(rd, 32'h3, "count register held");
    apb_rw(1'b1, SFQ_OFS_CTRL, 32'h0, rd, err);
    drain();
    hold_on <= 1'b0;
    // Global reset in mid-fill empties the queue
    stall <= 1'b1;
    for (int i = 0; i < 5; i++) push(rnd_word());
    s_valid <= 1'b0;
    @(posedge i_mclk);
    i_arestn <= 1'b0;
    @(posedge i_mclk);
    i_arestn <= 1'b1;
    expq.delete();
    repeat (3) @(posedge i_mclk);
    cmp_val(32'(count), 32'h0, "count after reset");
    cmp_val(32'(m_valid), 32'h0, "valid after reset");
    // Flush through the control register, then fresh traffic
    for (int i = 0; i < 4; i++) push(rnd_word());
    s_valid <= 1'b0;
    flushing <= 1'b1;
    apb_rw(1'b1, SFQ_OFS_CTRL, 32'h1, rd, err);
    expq.delete();
    repeat (3) @(posedge i_mclk);
    cmp_val(32'(count), 32'h0, "count after flush");
    flushing <= 1'b0;
    stall <= 1'b0;
    for (int i = 0; i < 3; i++) push(rnd_word());
    s_valid <= 1'b0;
    drain();
    give_verdict();
  end
endmodule // tb_stream_fifo_queue

`default_nettype wire
